// *** inc/cam_port_pkg.sv ***
// package for the parallel camera sensor input port
// assumes a 32-bit apb slave and a 20-bit sensor pixel bus
package cam_port_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int BUS_W = 20;
  localparam int COMP_W = 10;
  localparam int CFG_W = 8;
  localparam int HOLD_W = BUS_W + 3;
  localparam int ADDR_W = 12;

  // ****************************************************
  // clock and pixel clock range
  // ****************************************************
  localparam int SYS_CLK_KHZ = 10000;
  localparam int PIX_FREQ_MIN_KHZ = 10;
  localparam int PIX_FREQ_MAX_KHZ = 180000;

  // ****************************************************
  // register offsets (byte addresses)
  // ****************************************************
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] FRAMES_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] PIXEL_OFS = 12'h00c;

  // ****************************************************
  // control field positions and reset value
  // ****************************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_DUAL_BIT = 3;
  localparam int CTRL_NARROW_BIT = 4;
  localparam int CTRL_FSFALL_BIT = 5;
  localparam int CTRL_LSLOW_BIT = 6;
  localparam int CTRL_PIXFALL_BIT = 7;
  localparam logic [CFG_W-1:0] CTRL_RESET = 8'h00;

  // status field positions
  localparam int STAT_DROP_BIT = 0;
  localparam int STAT_FIELD_BIT = 1;
  localparam int STAT_LINES_LO = 16;

  // ****************************************************
  // sensor timing modes
  // ****************************************************
  typedef enum logic [1:0] {
    MODE_EMBEDDED,
    MODE_GATED,
    MODE_NONGATED,
    MODE_UNUSED
  } sensor_mode_t;

  // ****************************************************
  // embedded timing code words
  // ****************************************************
  localparam logic [COMP_W-1:0] CODE_ONES = 10'h3ff;
  localparam logic [COMP_W-1:0] CODE_ZERO = 10'h000;
  localparam int CODE_F_BIT = 8;
  localparam int CODE_V_BIT = 7;
  localparam int CODE_H_BIT = 6;

endpackage

// *** rtl/camera_sensor_input_port.sv ***
// parallel camera sensor input port with apb control
// assumes sensor data and syncs are timed to the sensor pixel clock
// and that software changes control only while capture is disabled
//
// Function
// - three modes: embedded, gated, non-gated clock
// - embedded mode uses only pixel clock
// - blanking between end and start dropped
// - codes removed, frame/line syncs rebuilt
// - single format: one component per clock
// - dual format: two components per clock
// - gated: frame begins on frame-sync edge
// - gated: pixels valid while line-sync active
// - data latched on chosen pixel clock edge
// - gated: line-sync inactive stops data accepting
// - non-gated: line-sync ignored, every clock pushes
// - frame edge, line level, clock edge programmable
// - pixel clock 0.01 to 180 MHz
// - narrow input: copy MSBs into LSBs
// - dual 20-bit format only with embedded codes
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module camera_sensor_input_port (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cam_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensor pins
  input wire logic sensorPixelClock,
  input wire logic sensorFrameSync,
  input wire logic sensorLineSync,
  input wire logic [cam_port_pkg::BUS_W-1:0] sensorPixelBus,
  // captured pixel stream
  output logic [cam_port_pkg::BUS_W-1:0] pixelData,
  output logic pixelValid,
  output logic frameStart,
  output logic lineStart
);
  import cam_port_pkg::*;

  // ****************************************************
  // system domain declarations
  // ****************************************************
  logic [CFG_W-1:0] ctrl_q;
  logic dropSticky_q;
  logic [15:0] frameCount_q;
  logic [15:0] lineCount_q;
  logic field_q;
  logic reqMeta_q;
  logic reqSync_q;
  logic reqSeen_q;
  logic newWord;
  logic setupPhase;
  logic accessPhase;
  logic addrHit;
  logic [31:0] readMux;
  logic [HOLD_W-1:0] hold_q;
  logic fieldMeta_q;
  logic fieldSync_q;

  // ****************************************************
  // pixel domain declarations
  // ****************************************************
  logic [CFG_W-1:0] cfgMeta_q;
  logic [CFG_W-1:0] cfg_q;
  logic [BUS_W-1:0] busP_q;
  logic [BUS_W-1:0] busN_q;
  logic fsP_q;
  logic fsN_q;
  logic lsP_q;
  logic lsN_q;
  logic [BUS_W-1:0] bus;
  logic fsAct;
  logic lsAct;
  logic fsPrev_q;
  logic lsPrev_q;
  logic frameEdge;
  logic lineEdge;
  sensor_mode_t mode;
  logic en;
  logic dualEff;
  logic narrow;
  logic codeHit;
  logic [BUS_W-1:0] decPix;
  logic decOk;
  logic decLine;
  logic decFrame;
  logic decField;
  logic pushReq;
  logic [BUS_W-1:0] pushWord;
  logic frameEv;
  logic lineEv;
  logic busy;
  logic accepted;
  logic pendFrame_q;
  logic pendLine_q;
  logic drop_q;
  logic reqTog_q;
  logic ackMeta_q;
  logic ackSync_q;

  // ****************************************************
  // control into the pixel domain
  // ****************************************************
  // quasi-static bits; each bit has its own two-stage synchroniser
  genvar gi;
  generate
    for (gi = 0; gi < CFG_W; gi++)
    begin : g_cfg
      always_ff @(posedge sensorPixelClock or posedge rst)
      begin
        if (rst)
        begin
          cfgMeta_q[gi] <= 1'b0;
          cfg_q[gi] <= 1'b0;
        end
        else
        begin
          cfgMeta_q[gi] <= ctrl_q[gi];
          cfg_q[gi] <= cfgMeta_q[gi];
        end
      end
    end
  endgenerate

  assign en = cfg_q[CTRL_EN_BIT];
  assign mode = sensor_mode_t'(cfg_q[CTRL_MODE_LO +: 2]);
  // dual lanes only when codes travel in the stream
  assign dualEff = cfg_q[CTRL_DUAL_BIT] && mode == MODE_EMBEDDED;
  assign narrow = cfg_q[CTRL_NARROW_BIT];

  // ****************************************************
  // pin capture on both pixel clock edges
  // ****************************************************
  // the sensor clock may stop between frames; nothing here needs it
  always_ff @(posedge sensorPixelClock or posedge rst)
  begin
    if (rst)
    begin
      busP_q <= '0;
      fsP_q <= 1'b0;
      lsP_q <= 1'b0;
    end
    else
    begin
      busP_q <= sensorPixelBus;
      fsP_q <= sensorFrameSync;
      lsP_q <= sensorLineSync;
    end
  end

  // falling-edge copy; used when the sensor launches on rising
  always_ff @(negedge sensorPixelClock or posedge rst)
  begin
    if (rst)
    begin
      busN_q <= '0;
      fsN_q <= 1'b0;
      lsN_q <= 1'b0;
    end
    else
    begin
      busN_q <= sensorPixelBus;
      fsN_q <= sensorFrameSync;
      lsN_q <= sensorLineSync;
    end
  end

  // edge and polarity selection
  assign bus = cfg_q[CTRL_PIXFALL_BIT] ? busN_q : busP_q;
  assign fsAct = (cfg_q[CTRL_PIXFALL_BIT] ? fsN_q : fsP_q)
    ^ cfg_q[CTRL_FSFALL_BIT];
  assign lsAct = (cfg_q[CTRL_PIXFALL_BIT] ? lsN_q : lsP_q)
    ^ cfg_q[CTRL_LSLOW_BIT];
  assign frameEdge = fsAct && !fsPrev_q;
  assign lineEdge = lsAct && !lsPrev_q;

  always_ff @(posedge sensorPixelClock or posedge rst)
  begin
    if (rst)
    begin
      fsPrev_q <= 1'b0;
      lsPrev_q <= 1'b0;
    end
    else
    begin
      fsPrev_q <= fsAct;
      lsPrev_q <= lsAct;
    end
  end

  // ****************************************************
  // embedded code decoder
  // ****************************************************
  // sync pins are not looked at in this mode
  embedded_sync_decoder u_dec (
    .pixClk(sensorPixelClock),
    .rst(rst),
    .wordIn(bus),
    .wordValid(en && mode == MODE_EMBEDDED),
    .codeHit(codeHit),
    .pixOut(decPix),
    .pixOk(decOk),
    .lineStart(decLine),
    .frameStart(decFrame),
    .field(decField)
  );

  // ****************************************************
  // mode selection of pushes and events
  // ****************************************************
  // unused mode code captures nothing
  always_comb
  begin
    pushReq = 1'b0;
    pushWord = bus;
    frameEv = 1'b0;
    lineEv = 1'b0;
    unique case (mode)
      MODE_EMBEDDED:
      begin
        pushReq = decOk;
        pushWord = decPix;
        frameEv = decFrame;
        lineEv = decLine;
      end
      MODE_GATED:
      begin
        pushReq = lsAct; // line-sync off stops data
        frameEv = frameEdge;
        lineEv = lineEdge;
      end
      MODE_NONGATED:
      begin
        pushReq = 1'b1; // line-sync ignored
        frameEv = frameEdge;
      end
      MODE_UNUSED:
      begin
        pushReq = 1'b0;
      end
    endcase
    pushReq = pushReq && en;
    frameEv = frameEv && en;
    lineEv = lineEv && en;
  end

  // colour extension of one lane
  function automatic logic [COMP_W-1:0] extend(
    input logic [COMP_W-1:0] c,
    input logic nar
  );
    extend = nar ? {c[COMP_W-1:2], c[COMP_W-1 -: 2]} : c;
  endfunction

  // ****************************************************
  // handshake word toward the system clock
  // ****************************************************
  // one word in flight; pushes while busy are dropped and flagged,
  // since a 180 MHz sensor far outruns the 10 MHz side
  assign busy = reqTog_q ^ ackSync_q;
  assign accepted = pushReq && !busy;

  always_ff @(posedge sensorPixelClock or posedge rst)
  begin
    if (rst)
    begin
      hold_q <= '0;
      reqTog_q <= 1'b0;
      pendFrame_q <= 1'b0;
      pendLine_q <= 1'b0;
      drop_q <= 1'b0;
    end
    else
    begin
      pendFrame_q <= accepted ? 1'b0 : (pendFrame_q || frameEv);
      pendLine_q <= accepted ? 1'b0 : (pendLine_q || lineEv);
      drop_q <= accepted ? 1'b0 : (drop_q || (pushReq && busy));
      if (accepted)
      begin
        reqTog_q <= !reqTog_q;
        hold_q[BUS_W+2] <= pendFrame_q || frameEv;
        hold_q[BUS_W+1] <= pendLine_q || lineEv;
        hold_q[BUS_W] <= drop_q;
        hold_q[BUS_W-1 -: COMP_W] <=
          extend(pushWord[BUS_W-1 -: COMP_W], narrow);
        // second lane only in dual format
        hold_q[COMP_W-1:0] <= dualEff ?
          extend(pushWord[COMP_W-1:0], narrow) : '0;
      end
    end
  end

  // ack back into the pixel domain
  always_ff @(posedge sensorPixelClock or posedge rst)
  begin
    if (rst)
    begin
      ackMeta_q <= 1'b0;
      ackSync_q <= 1'b0;
    end
    else
    begin
      ackMeta_q <= reqSeen_q;
      ackSync_q <= ackMeta_q;
    end
  end

  // ****************************************************
  // system side of the handshake
  // ****************************************************
  // hold_q is stable while the toggle is in flight
  assign newWord = reqSync_q ^ reqSeen_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reqMeta_q <= 1'b0;
      reqSync_q <= 1'b0;
      reqSeen_q <= 1'b0;
      fieldMeta_q <= 1'b0;
      fieldSync_q <= 1'b0;
    end
    else
    begin
      reqMeta_q <= reqTog_q;
      reqSync_q <= reqMeta_q;
      reqSeen_q <= reqSync_q;
      fieldMeta_q <= decField;
      fieldSync_q <= fieldMeta_q;
    end
  end

  // stream outputs, one-cycle pulses
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pixelData <= '0;
      pixelValid <= 1'b0;
      frameStart <= 1'b0;
      lineStart <= 1'b0;
    end
    else
    begin
      pixelValid <= newWord;
      frameStart <= newWord && hold_q[BUS_W+2];
      lineStart <= newWord && hold_q[BUS_W+1];
      if (newWord)
        pixelData <= hold_q[BUS_W-1:0];
    end
  end

  // ****************************************************
  // apb slave
  // ****************************************************
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable && pready;
  assign addrHit = paddr == CTRL_OFS || paddr == STATUS_OFS
    || paddr == FRAMES_OFS || paddr == PIXEL_OFS;

  always_comb
  begin
    readMux = 32'h0000_0000;
    if (paddr == CTRL_OFS)
      readMux[CFG_W-1:0] = ctrl_q;
    else if (paddr == STATUS_OFS)
    begin
      readMux[STAT_DROP_BIT] = dropSticky_q;
      readMux[STAT_FIELD_BIT] = field_q;
      readMux[STAT_LINES_LO +: 16] = lineCount_q;
    end
    else if (paddr == FRAMES_OFS)
      readMux[15:0] = frameCount_q;
    else if (paddr == PIXEL_OFS)
      readMux[BUS_W-1:0] = pixelData;
  end

  // answer registered in setup, so access ends without wait
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setupPhase;
      pslverr <= setupPhase && !addrHit;
      if (setupPhase)
        prdata <= pwrite ? 32'h0000_0000 : readMux;
    end
  end

  // control register; selects mode, format, polarities
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ctrl_q <= CTRL_RESET;
    else if (accessPhase && pwrite && paddr == CTRL_OFS)
      ctrl_q <= pwdata[CFG_W-1:0];
  end

  // status: drop flag is write-one-to-clear, a new drop wins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dropSticky_q <= 1'b0;
      frameCount_q <= 16'h0000;
      lineCount_q <= 16'h0000;
      field_q <= 1'b0;
    end
    else
    begin
      field_q <= fieldSync_q;
      dropSticky_q <= (newWord && hold_q[BUS_W]) || (dropSticky_q
        && !(accessPhase && pwrite && paddr == STATUS_OFS
        && pwdata[STAT_DROP_BIT]));
      if (newWord && hold_q[BUS_W+2])
      begin
        frameCount_q <= frameCount_q + 16'h0001;
        lineCount_q <= {15'h0000, hold_q[BUS_W+1]}; // first line counts
      end
      else if (newWord && hold_q[BUS_W+1])
        lineCount_q <= lineCount_q + 16'h0001;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  AST_APB_NO_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
    setupPhase |=> pready ##1 !pready)
    else $error("apb access not answered in one cycle");

  AST_CTRL_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    accessPhase && pwrite && paddr == CTRL_OFS
    |=> ctrl_q == $past(pwdata[CFG_W-1:0]))
    else $error("control write not stored");

  AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (rst)
    accessPhase && !addrHit |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped address not refused");

  AST_GATED_STOP: assert property (
    @(posedge sensorPixelClock) disable iff (rst)
    mode == MODE_GATED && !lsAct |-> !pushReq)
    else $error("gated mode pushed outside line");

  AST_NONGATED_PUSH: assert property (
    @(posedge sensorPixelClock) disable iff (rst)
    en && mode == MODE_NONGATED && !busy
    |=> reqTog_q != $past(reqTog_q))
    else $error("non-gated clock did not push");

  AST_CODE_CUT: assert property (
    @(posedge sensorPixelClock) disable iff (rst)
    mode == MODE_EMBEDDED && codeHit |=> !decOk ##1 !decOk)
    else $error("timing code passed as pixel");

  AST_DUAL_EMBED_ONLY: assert property (
    @(posedge sensorPixelClock) disable iff (rst)
    accepted && mode != MODE_EMBEDDED
    |=> hold_q[COMP_W-1:0] == '0)
    else $error("second lane used without codes");

  AST_EXTEND: assert property (@(posedge sys_clk) disable iff (rst)
    pixelValid && ctrl_q[CTRL_NARROW_BIT]
    && $stable(ctrl_q) && $past(ctrl_q, 8) == ctrl_q
    |-> pixelData[BUS_W-COMP_W +: 2] == pixelData[BUS_W-1 -: 2])
    else $error("colour extension missing");

  AST_FRAME_COUNT: assert property (@(posedge sys_clk) disable iff (rst)
    newWord && hold_q[BUS_W+2]
    |=> frameStart && frameCount_q == $past(frameCount_q) + 16'h0001)
    else $error("frame start not counted");

endmodule // camera_sensor_input_port

// *** rtl/embedded_sync_decoder.sv ***
// decoder for timing codes carried inside the pixel stream
// assumes the luma lane on the upper component of the word
`timescale 1ns/1ns
module embedded_sync_decoder (
  // pixel clock domain
  input wire logic pixClk,
  input wire logic rst,
  // incoming words
  input wire logic [cam_port_pkg::BUS_W-1:0] wordIn,
  input wire logic wordValid,
  // decoded stream
  output logic codeHit,
  output logic [cam_port_pkg::BUS_W-1:0] pixOut,
  output logic pixOk,
  output logic lineStart,
  output logic frameStart,
  output logic field
);
  import cam_port_pkg::*;

  logic [BUS_W-1:0] hist_q [3];
  logic [2:0] act_q;
  logic active_q;
  logic vblank_q;
  logic [COMP_W-1:0] lumaIn;
  logic isSav;

  // ****************************************************
  // preamble match on the luma lane
  // ****************************************************
  // three-word preamble then status word
  assign lumaIn = wordIn[BUS_W-1 -: COMP_W];
  assign codeHit = wordValid
    && hist_q[2][BUS_W-1 -: COMP_W] == CODE_ONES
    && hist_q[1][BUS_W-1 -: COMP_W] == CODE_ZERO
    && hist_q[0][BUS_W-1 -: COMP_W] == CODE_ZERO;
  assign isSav = codeHit && !lumaIn[CODE_H_BIT];

  // ****************************************************
  // three-word delay so a code can be cut out
  // ****************************************************
  // preamble words were already queued as pixels; kill them
  always_ff @(posedge pixClk or posedge rst)
  begin
    if (rst)
    begin
      hist_q[0] <= '0;
      hist_q[1] <= '0;
      hist_q[2] <= '0;
      act_q <= 3'h0;
      pixOk <= 1'b0;
      pixOut <= '0;
    end
    else
    begin
      pixOk <= 1'b0;
      if (wordValid)
      begin
        hist_q[0] <= wordIn;
        hist_q[1] <= hist_q[0];
        hist_q[2] <= hist_q[1];
        act_q <= codeHit ? 3'h0 : {act_q[1:0], active_q};
        pixOk <= act_q[2] && !codeHit; // blanking never passes
        pixOut <= hist_q[2];
      end
    end
  end

  // ****************************************************
  // rebuilt frame and line timing
  // ****************************************************
  // line opens on start code, closes on end code
  always_ff @(posedge pixClk or posedge rst)
  begin
    if (rst)
    begin
      active_q <= 1'b0;
      vblank_q <= 1'b1;
      field <= 1'b0;
      lineStart <= 1'b0;
      frameStart <= 1'b0;
    end
    else
    begin
      lineStart <= isSav && !lumaIn[CODE_V_BIT];
      frameStart <= isSav && !lumaIn[CODE_V_BIT] && vblank_q;
      if (codeHit)
      begin
        active_q <= !lumaIn[CODE_H_BIT] && !lumaIn[CODE_V_BIT];
        vblank_q <= lumaIn[CODE_V_BIT];
        field <= lumaIn[CODE_F_BIT];
      end
    end
  end

endmodule // embedded_sync_decoder

// *** test/camera_sensor_input_port_bench.sv ***
// self-checking bench for the camera sensor input port
// assumes sensor_model on the pins and a zero-wait apb slave
`timescale 1ns/1ns
module camera_sensor_input_port_bench;
  import cam_port_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic pixClk, fsPin, lsPin, pixelValid, frameStart, lineStart;
  logic [BUS_W-1:0] busPin, pixelData, gotData, d;
  int errors, compares, cyc, nGot, nLine, nFrame, n0, l0, f0;

  camera_sensor_input_port dut (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sensorPixelClock(pixClk),
    .sensorFrameSync(fsPin), .sensorLineSync(lsPin),
    .sensorPixelBus(busPin), .pixelData(pixelData),
    .pixelValid(pixelValid), .frameStart(frameStart),
    .lineStart(lineStart));
  sensor_model sensor (.pixClk(pixClk), .frameSync(fsPin),
    .lineSync(lsPin), .pixBus(busPin));

  // ****
  // clock, monitor and hang guard
  // ****
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // counts words and their markers; pulses last one cycle only
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (pixelValid === 1'b1)
    begin
      gotData <= pixelData;
      nGot <= nGot + 1;
      nLine <= nLine + lineStart;
      nFrame <= nFrame + frameStart;
    end
    if (cyc == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected word: C lane only in dual, narrow copies top bits down
  function automatic logic [19:0] expw(logic [19:0] w, logic du,
    logic na);
    logic [9:0] y, c;
    y = w[19:10];
    c = du ? w[9:0] : 10'h000;
    if (na)
    begin
      y[1:0] = y[9:8];
      c[1:0] = c[9:8];
    end
    return {y, c};
  endfunction

  task automatic chk(input string what, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no assumed latency; only the cycle ceiling ends a hang
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // disable, let the pixel side see it, then program and read back
  task automatic setup(input logic [7:0] ctl);
    apb(1'b1, CTRL_OFS, 32'h0);
    repeat (4) sensor.idle(ctl[5], ctl[6]);
    apb(1'b1, CTRL_OFS, {24'h0, ctl});
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", {24'h0, ctl}, rd);
    repeat (4) sensor.idle(ctl[5], ctl[6]);
    n0 = nGot;
    l0 = nLine;
    f0 = nFrame;
  endtask

  task automatic counts(input int w, l, f);
    chk("words", w, nGot - n0);
    chk("lines", l, nLine - l0);
    chk("frames", f, nFrame - f0);
  endtask

  task automatic code(input logic [9:0] s);
    sensor.tick({CODE_ONES, CODE_ONES}, 1'b0, 1'b0);
    sensor.tick({CODE_ZERO, CODE_ZERO}, 1'b1, 1'b0);
    sensor.tick({CODE_ZERO, CODE_ZERO}, 1'b0, 1'b1);
    sensor.tick({s, s}, 1'b1, 1'b1);
  endtask

  // ****
  // scenarios
  // ****
  task automatic gated(input logic [7:0] ctl);
    setup(ctl);
    sensor.idle(~ctl[5], ctl[6]); // frame edge
    repeat (3)
    begin
      d = rnd();
      sensor.tick(d, ~ctl[5], ~ctl[6]); // one word in line
      repeat (14) sensor.idle(~ctl[5], ctl[6]);
      chk("pixel", expw(d, 1'b0, ctl[4]), gotData);
    end
    counts(3, 3, 1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("line count", 32'h3, {16'h0, rd[31:16]});
  endtask

  // syncs toggle at random to show they are ignored
  task automatic embedded(input logic [7:0] ctl);
    setup(ctl);
    code(10'h2c0); // vertical blanking code
    repeat (3)
    begin
      code(10'h200); // start of active video
      d = rnd();
      d[19:18] = 2'b01;
      sensor.tick(d, d[0], d[1]);
      code(10'h240); // end of active video
      repeat (18)
      begin
        seed = rnd();
        sensor.tick({10'h040, seed[9:0]}, seed[10], seed[11]);
      end
      chk("pixel", expw(d, ctl[3], ctl[4]), gotData);
    end
    counts(3, 3, 1);
  endtask

  // ****
  // main sequence
  // ****
  initial
  begin
    seed = 32'hbe24;
    {errors, compares, cyc, nGot, nLine, nFrame} = '0;
    gotData = '0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl reset", {24'h0, CTRL_RESET}, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    gated(8'h03);
    gated(8'he3);
    gated(8'h13);
    gated(8'h0b); // dual bit set without codes
    embedded(8'h01);
    embedded(8'h09);
    embedded(8'h19);
    // non-gated: line sync held inactive, clock only for data
    setup(8'h05);
    d = rnd();
    repeat (4)
    begin
      sensor.tick(d, 1'b0, 1'b0);
      #1200;
    end
    chk("pixel", expw(d, 1'b0, 1'b0), gotData);
    apb(1'b0, PIXEL_OFS, 32'h0);
    chk("pixel reg", {12'h0, expw(d, 1'b0, 1'b0)}, rd);
    // back-to-back edges overrun the crossing
    sensor.tick(~d, 1'b0, 1'b0);
    sensor.tick(d, 1'b0, 1'b0);
    #1200;
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("drop", 32'h1, {31'h0, rd[STAT_DROP_BIT]});
    apb(1'b1, STATUS_OFS, 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("drop clr", 32'h0, {31'h0, rd[STAT_DROP_BIT]});
    // unused mode code: nothing captured whatever the pins do
    setup(8'h07);
    repeat (8)
    begin
      seed = rnd();
      sensor.tick(seed[19:0], seed[20], seed[21]);
    end
    #1200;
    counts(0, 0, 0);
    finish_test();
  end

  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
endmodule // camera_sensor_input_port_bench

// *** test/sensor_model.sv ***
// behavioural parallel image sensor driving the pixel pins
// assumes the bench calls tick once for each pixel clock period
`timescale 1ns/1ns
module sensor_model (
  // sensor pins
  output logic pixClk,
  output logic frameSync,
  output logic lineSync,
  output logic [19:0] pixBus
);
  // clock rests low between ticks, no free run
  initial
  begin
    pixClk = 1'b0;
    frameSync = 1'b0;
    lineSync = 1'b0;
    pixBus = 20'h0;
  end

  // one 64 ns period; pins move 8 ns after the last fall so that
  // either latching edge sees settled data
  task automatic tick(input logic [19:0] d, input logic fs,
    input logic ls);
    #8;
    pixBus = d;
    frameSync = fs;
    lineSync = ls;
    #24 pixClk = 1'b1;
    #32 pixClk = 1'b0;
  endtask

  // bus released: inverse of the last word, never a stale copy
  task automatic idle(input logic fs, input logic ls);
    tick(~pixBus, fs, ls);
  endtask
endmodule // sensor_model
